// ==== optical_pulse.sv ====
// optical port pin logic and energy pulse shaping, with an AXI4-Lite register slave
// assumes synchronous inputs, one 250 MHz clock and one write and one read in flight
//
// The AXI4-Lite interface to the registers is this design's own decision.
`timescale 1ns/1ns
`default_nettype none
module optical_pulse
  import optical_pulse_pkg::*;
#(
  parameter int unsigned SAMPLE_CYC = optical_pulse_pkg::SAMPLE_CYCLES
)(
  input wire logic clk_sys, // system clock
  input wire logic rst_b, // async reset, active low
  input wire logic [optical_pulse_pkg::ADDR_W-1:0] s_axi_awaddr, // write address
  input wire logic s_axi_awvalid, // write address valid
  output logic s_axi_awready, // write address ready
  input wire logic [31:0] s_axi_wdata, // write data
  input wire logic [3:0] s_axi_wstrb, // write strobes
  input wire logic s_axi_wvalid, // write data valid
  output logic s_axi_wready, // write data ready
  output logic [1:0] s_axi_bresp, // write response
  output logic s_axi_bvalid, // write response valid
  input wire logic s_axi_bready, // write response ready
  input wire logic [optical_pulse_pkg::ADDR_W-1:0] s_axi_araddr, // read address
  input wire logic s_axi_arvalid, // read address valid
  output logic s_axi_arready, // read address ready
  output logic [31:0] s_axi_rdata, // read data
  output logic [1:0] s_axi_rresp, // read response
  output logic s_axi_rvalid, // read data valid
  input wire logic s_axi_rready, // read data ready
  input wire logic [1:0] ce_pulse, // pulse requests, bit 0 real, bit 1 reactive
  output logic real_energy_pulse, // shaped real energy pulse pin
  output logic reactive_energy_pulse, // shaped reactive energy pulse pin
  input wire logic ir_rx_pin, // comparator result of the optical receive pin
  output logic uart_rx, // value to the optical uart receiver
  output logic general_io_line_one, // rx pin seen as gpio input
  input wire logic uart_tx, // optical uart transmit line
  input wire logic general_io_line_two, // gpio output line two
  output logic ir_tx_pin // optical transmit pin
);

  function automatic logic [15:0] reg_index(input logic [ADDR_W-1:0] a);
    reg_index = a[ADDR_W-1:2];
  endfunction

  function automatic logic is_mapped(input logic [15:0] idx);
    is_mapped = (idx == IDX_PULSE_CTRL) || (idx == IDX_OPT_SEL) || (idx == IDX_OPT_CTRL)
      || (idx == IDX_MAX_WIDTH) || (idx == IDX_INTERVAL) || (idx == IDX_STATUS);
  endfunction

  cfg_t cfg_reg, cfg_next;
  logic aw_held_reg, aw_held_next, w_held_reg, w_held_next;
  logic [ADDR_W-1:0] awaddr_reg, awaddr_next;
  logic [31:0] wdata_reg, wdata_next;
  logic wstrb0_reg, wstrb0_next;
  logic bvalid_reg, bvalid_next, rvalid_reg, rvalid_next;
  logic [1:0] bresp_reg, bresp_next, rresp_reg, rresp_next;
  logic [31:0] rdata_reg, rdata_next;
  logic [15:0] widx, ridx;
  logic [7:0] status_byte;

  logic [1:0] pulse_active;
  logic [1:0] pulse_out_reg, pulse_out_next;

  // write and read channels
  always_comb
  begin
    aw_held_next = aw_held_reg;
    w_held_next = w_held_reg;
    awaddr_next = awaddr_reg;
    wdata_next = wdata_reg;
    wstrb0_next = wstrb0_reg;
    bvalid_next = bvalid_reg;
    bresp_next = bresp_reg;
    rvalid_next = rvalid_reg;
    rresp_next = rresp_reg;
    rdata_next = rdata_reg;
    cfg_next = cfg_reg;
    widx = reg_index(awaddr_reg);
    ridx = reg_index(s_axi_araddr);
    if (s_axi_awvalid && s_axi_awready)
    begin
      aw_held_next = 1'b1;
      awaddr_next = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready)
    begin
      w_held_next = 1'b1;
      wdata_next = s_axi_wdata;
      wstrb0_next = s_axi_wstrb[0];
    end
    if (bvalid_reg && s_axi_bready)
      bvalid_next = 1'b0;
    if (aw_held_reg && w_held_reg && !bvalid_reg)
    begin
      aw_held_next = 1'b0;
      w_held_next = 1'b0;
      bvalid_next = 1'b1;
      bresp_next = is_mapped(widx) ? RESP_OKAY : RESP_SLVERR;
      if (wstrb0_reg)
      begin
        case (widx)
          IDX_PULSE_CTRL: cfg_next.pulse_polarity_invert = wdata_reg[POS_PULSE_INV];
          IDX_OPT_SEL:
          begin
            cfg_next.modulation_duty_select = wdata_reg[POS_DUTY +: 2];
            cfg_next.tx_pin_source_select = wdata_reg[POS_TX_SRC +: 2];
          end
          IDX_OPT_CTRL:
          begin
            cfg_next.tx_invert = wdata_reg[POS_TX_INVERT];
            cfg_next.tx_modulate_enable = wdata_reg[POS_TX_MOD];
            cfg_next.rx_invert = wdata_reg[POS_RX_INVERT];
            cfg_next.rx_pin_as_gpio = wdata_reg[POS_RX_GPIO];
          end
          IDX_MAX_WIDTH: cfg_next.pulse_max_width = wdata_reg[7:0];
          IDX_INTERVAL: cfg_next.pulse_interval = wdata_reg[7:0];
          default: cfg_next = cfg_reg;
        endcase
      end
    end
    if (rvalid_reg && s_axi_rready)
      rvalid_next = 1'b0;
    if (s_axi_arvalid && s_axi_arready)
    begin
      rvalid_next = 1'b1;
      rresp_next = is_mapped(ridx) ? RESP_OKAY : RESP_SLVERR;
      rdata_next = 32'h0;
      case (ridx)
        IDX_PULSE_CTRL: rdata_next[POS_PULSE_INV] = cfg_reg.pulse_polarity_invert;
        IDX_OPT_SEL:
        begin
          rdata_next[POS_DUTY +: 2] = cfg_reg.modulation_duty_select;
          rdata_next[POS_TX_SRC +: 2] = cfg_reg.tx_pin_source_select;
        end
        IDX_OPT_CTRL:
        begin
          rdata_next[POS_TX_INVERT] = cfg_reg.tx_invert;
          rdata_next[POS_TX_MOD] = cfg_reg.tx_modulate_enable;
          rdata_next[POS_RX_INVERT] = cfg_reg.rx_invert;
          rdata_next[POS_RX_GPIO] = cfg_reg.rx_pin_as_gpio;
        end
        IDX_MAX_WIDTH: rdata_next[7:0] = cfg_reg.pulse_max_width;
        IDX_INTERVAL: rdata_next[7:0] = cfg_reg.pulse_interval;
        IDX_STATUS: rdata_next[7:0] = status_byte;
        default: rdata_next = 32'h0;
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      cfg_reg <= CFG_RESET;
      aw_held_reg <= 1'b0;
      w_held_reg <= 1'b0;
      awaddr_reg <= '0;
      wdata_reg <= 32'h0;
      wstrb0_reg <= 1'b0;
      bvalid_reg <= 1'b0;
      bresp_reg <= RESP_OKAY;
      rvalid_reg <= 1'b0;
      rresp_reg <= RESP_OKAY;
      rdata_reg <= 32'h0;
    end
    else
    begin
      cfg_reg <= cfg_next;
      aw_held_reg <= aw_held_next;
      w_held_reg <= w_held_next;
      awaddr_reg <= awaddr_next;
      wdata_reg <= wdata_next;
      wstrb0_reg <= wstrb0_next;
      bvalid_reg <= bvalid_next;
      bresp_reg <= bresp_next;
      rvalid_reg <= rvalid_next;
      rresp_reg <= rresp_next;
      rdata_reg <= rdata_next;
    end
  end

  assign s_axi_awready = !aw_held_reg && !bvalid_reg;
  assign s_axi_wready = !w_held_reg && !bvalid_reg;
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;
  assign s_axi_arready = !rvalid_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rresp = rresp_reg;
  assign s_axi_rdata = rdata_reg;

  // shared time unit for pulse limiting and queue pacing
  logic bypass;
  logic [31:0] unit_len;
  logic [31:0] unit_cnt_reg, unit_cnt_next;
  logic unit_tick;

  always_comb
  begin
    bypass = (cfg_reg.pulse_interval == 8'h00);
    unit_len = bypass ? 32'(SAMPLE_CYC)
      : 32'(cfg_reg.pulse_interval) * 32'(UNIT_CYCLES);
    unit_tick = (unit_cnt_reg >= unit_len - 32'h1);
    unit_cnt_next = unit_tick ? 32'h0 : unit_cnt_reg + 32'h1;
  end

  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
      unit_cnt_reg <= 32'h0;
    else
      unit_cnt_reg <= unit_cnt_next;
  end

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++)
    begin : g_pulse
      pulse_state_t st_reg, st_next;
      logic [8:0] units_reg, units_next;
      logic [31:0] cyc_reg, cyc_next, period_reg, period_next, half_reg, half_next;
      logic [3:0] pend_reg, pend_next;
      logic start;
      logic [8:0] limit;

      always_comb
      begin
        st_next = st_reg;
        units_next = units_reg;
        cyc_next = cyc_reg + 32'h1;
        half_next = half_reg;
        pend_next = pend_reg;
        period_next = (period_reg == 32'hFFFF_FFFF) ? period_reg : period_reg + 32'h1;
        limit = {cfg_reg.pulse_max_width, 1'b1};
        // queued requests start only on a unit boundary, so starts are paced
        if (bypass)
          start = ce_pulse[gi];
        else
          start = unit_tick && (pend_reg != 4'h0) && (st_reg == PS_IDLE);
        if (!bypass && ce_pulse[gi] && pend_reg != PEND_MAX)
          pend_next = pend_reg + 4'h1;
        if (start && !bypass)
          pend_next = pend_next - 4'h1;
        case (st_reg)
          PS_IDLE: st_next = PS_IDLE;
          PS_ACTIVE:
          begin
            if (cfg_reg.pulse_max_width == MAX_WIDTH_OFF)
            begin
              if (cyc_next >= half_reg)
                st_next = PS_IDLE;
            end
            else if (unit_tick)
            begin
              units_next = units_reg + 9'h1;
              if (units_next >= limit)
                st_next = PS_IDLE;
            end
          end
          default: st_next = PS_IDLE;
        endcase
        if (start)
        begin
          // half the spacing since the previous start gives 50 percent duty
          st_next = PS_ACTIVE;
          units_next = 9'h0;
          cyc_next = 32'h0;
          half_next = {1'b0, period_reg[31:1]};
          period_next = 32'h1;
        end
      end

      always_ff @(posedge clk_sys or negedge rst_b)
      begin
        if (!rst_b)
        begin
          st_reg <= PS_IDLE;
          units_reg <= 9'h0;
          cyc_reg <= 32'h0;
          half_reg <= 32'h0;
          pend_reg <= 4'h0;
          period_reg <= 32'hFFFF_FFFF;
        end
        else
        begin
          st_reg <= st_next;
          units_reg <= units_next;
          cyc_reg <= cyc_next;
          half_reg <= half_next;
          pend_reg <= pend_next;
          period_reg <= period_next;
        end
      end

      assign pulse_active[gi] = (st_reg == PS_ACTIVE);
    end
  endgenerate

  // optical transmit path and carrier
  logic [31:0] step_cnt_reg, step_cnt_next;
  logic [3:0] phase_reg, phase_next;
  logic carrier, tx_src, tx_inv, tx_next, tx_reg;
  logic uart_rx_next, uart_rx_reg, gpio_one_next, gpio_one_reg;

  always_comb
  begin
    step_cnt_next = step_cnt_reg + 32'h1;
    phase_next = phase_reg;
    if (step_cnt_reg >= 32'(CARRIER_STEP_CYCLES) - 32'h1)
    begin
      step_cnt_next = 32'h0;
      phase_next = phase_reg + 4'h1;
    end
    // low while phase is below 8, 4, 2 or 1 of 16 steps
    carrier = !({1'b0, phase_reg} < (5'h8 >> cfg_reg.modulation_duty_select));
    pulse_out_next = cfg_reg.pulse_polarity_invert ? pulse_active : ~pulse_active;
    case (cfg_reg.tx_pin_source_select)
      SRC_UART: tx_src = uart_tx;
      SRC_GPIO_TWO: tx_src = general_io_line_two;
      SRC_REAL: tx_src = pulse_out_reg[0];
      SRC_REACTIVE: tx_src = pulse_out_reg[1];
      default: tx_src = uart_tx;
    endcase
    tx_inv = tx_src ^ cfg_reg.tx_invert;
    tx_next = (cfg_reg.tx_modulate_enable && !tx_inv) ? carrier : tx_inv;
    uart_rx_next = cfg_reg.rx_pin_as_gpio ? 1'b1 : (ir_rx_pin ^ cfg_reg.rx_invert);
    gpio_one_next = cfg_reg.rx_pin_as_gpio ? ir_rx_pin : 1'b0;
  end

  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      step_cnt_reg <= 32'h0;
      phase_reg <= 4'h0;
      pulse_out_reg <= 2'h3;
      tx_reg <= 1'b0;
      uart_rx_reg <= 1'b1;
      gpio_one_reg <= 1'b0;
    end
    else
    begin
      step_cnt_reg <= step_cnt_next;
      phase_reg <= phase_next;
      pulse_out_reg <= pulse_out_next;
      tx_reg <= tx_next;
      uart_rx_reg <= uart_rx_next;
      gpio_one_reg <= gpio_one_next;
    end
  end

  assign status_byte = {2'h0, pulse_active, pulse_out_reg, ir_rx_pin, tx_reg};
  assign real_energy_pulse = pulse_out_reg[0];
  assign reactive_energy_pulse = pulse_out_reg[1];
  assign ir_tx_pin = tx_reg;
  assign uart_rx = uart_rx_reg;
  assign general_io_line_one = gpio_one_reg;

endmodule
`default_nettype wire

// ==== optical_pulse_pkg.sv ====
// constants, register map and types for the optical port and energy pulse shaper
// assumes a 250 MHz system clock and an AXI4-Lite register bus with 32-bit data
package optical_pulse_pkg;

  localparam int unsigned CLK_MHZ = 250;
  localparam int unsigned SAMPLE_TIME_US = 397;
  localparam int unsigned SAMPLE_CYCLES = SAMPLE_TIME_US * CLK_MHZ;
  localparam int unsigned UNIT_TIME_NS = 1000;
  localparam int unsigned UNIT_CYCLES = (UNIT_TIME_NS * CLK_MHZ) / 1000;
  localparam int unsigned CARRIER_STEP_NS = 1644;
  localparam int unsigned CARRIER_STEP_CYCLES = (CARRIER_STEP_NS * CLK_MHZ) / 1000;

  localparam int ADDR_W = 18;
  // register indices; byte address is four times the index
  localparam logic [15:0] IDX_PULSE_CTRL = 16'h2004;
  localparam logic [15:0] IDX_OPT_SEL = 16'h2007;
  localparam logic [15:0] IDX_OPT_CTRL = 16'h2008;
  localparam logic [15:0] IDX_MAX_WIDTH = 16'h2080;
  localparam logic [15:0] IDX_INTERVAL = 16'h2081;
  localparam logic [15:0] IDX_STATUS = 16'h2082;

  localparam int POS_PULSE_INV = 6;
  localparam int POS_DUTY = 0;
  localparam int POS_TX_SRC = 6;
  localparam int POS_TX_INVERT = 0;
  localparam int POS_TX_MOD = 1;
  localparam int POS_RX_INVERT = 4;
  localparam int POS_RX_GPIO = 5;

  localparam logic [7:0] RST_MAX_WIDTH = 8'hFF;
  localparam logic [7:0] RST_INTERVAL = 8'h00;
  localparam logic [7:0] MAX_WIDTH_OFF = 8'hFF;
  localparam logic [3:0] PEND_MAX = 4'hF;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  localparam logic [1:0] SRC_UART = 2'h0;
  localparam logic [1:0] SRC_GPIO_TWO = 2'h1;
  localparam logic [1:0] SRC_REAL = 2'h2;
  localparam logic [1:0] SRC_REACTIVE = 2'h3;

  typedef struct packed {
    logic [1:0] tx_pin_source_select;
    logic [1:0] modulation_duty_select;
    logic rx_pin_as_gpio;
    logic rx_invert;
    logic tx_modulate_enable;
    logic tx_invert;
    logic pulse_polarity_invert;
    logic [7:0] pulse_max_width;
    logic [7:0] pulse_interval;
  } cfg_t;

  localparam cfg_t CFG_RESET = '{2'h0, 2'h0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0,
                                 RST_MAX_WIDTH, RST_INTERVAL};

  typedef enum logic {PS_IDLE, PS_ACTIVE} pulse_state_t;

endpackage

// ==== optical_pulse_properties.sv ====
// bus handshake and pin relations of the optical port block
// assumes only the top module's ports; bound to every instance below
`timescale 1ns/1ns
`default_nettype none
module optical_pulse_properties (
  input wire logic clk_sys, // clock
  input wire logic rst_b, // reset, active low
  input wire logic s_axi_awvalid, // aw valid
  input wire logic s_axi_awready, // aw ready
  input wire logic s_axi_wvalid, // w valid
  input wire logic s_axi_wready, // w ready
  input wire logic s_axi_bvalid, // b valid
  input wire logic s_axi_bready, // b ready
  input wire logic s_axi_arvalid, // ar valid
  input wire logic s_axi_arready, // ar ready
  input wire logic s_axi_rvalid, // r valid
  input wire logic s_axi_rready, // r ready
  input wire logic [1:0] ce_pulse, // pulse requests
  input wire logic real_energy_pulse, // real pulse pin
  input wire logic ir_rx_pin, // receive pin
  input wire logic uart_rx, // uart receive value
  input wire logic general_io_line_one // gpio input
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  sequence s_wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_rd_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence
  property p_wr_resp;
    s_wr_taken |-> ##2 s_axi_bvalid;
  endproperty
  property p_rd_resp;
    s_rd_taken |=> s_axi_rvalid;
  endproperty
  property p_b_done;
    s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid;
  endproperty
  property p_r_done;
    s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid;
  endproperty
  property p_w_refused;
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
  endproperty
  property p_ar_refused;
    s_axi_rvalid |-> !s_axi_arready;
  endproperty
  property p_line_one;
    general_io_line_one |-> $past(ir_rx_pin);
  endproperty
  property p_gpio_uart_idle;
    general_io_line_one |-> uart_rx;
  endproperty
  // a new low on the real pin needs a request two edges back or a polarity write
  property p_real_start;
    $fell(real_energy_pulse) |-> $past(ce_pulse[0], 2) || $past(s_axi_bvalid)
      || $past(s_axi_bvalid, 2);
  endproperty
  a_wr_resp: assert property (p_wr_resp)
    else $error("write response missing");
  a_rd_resp: assert property (p_rd_resp)
    else $error("read data missing");
  a_b_done: assert property (p_b_done)
    else $error("write response not cleared");
  a_r_done: assert property (p_r_done)
    else $error("read data not cleared");
  a_w_refused: assert property (p_w_refused)
    else $error("write taken during response");
  a_ar_refused: assert property (p_ar_refused)
    else $error("read taken during data");
  a_line_one: assert property (p_line_one)
    else $error("gpio line not from receive pin");
  a_gpio_uart_idle: assert property (p_gpio_uart_idle)
    else $error("uart value not idle in gpio mode");
  a_real_start: assert property (p_real_start)
    else $error("real pulse started without cause");
endmodule
bind optical_pulse optical_pulse_properties u_props (.clk_sys, .rst_b, .s_axi_awvalid,
  .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .ce_pulse, .real_energy_pulse, .ir_rx_pin,
  .uart_rx, .general_io_line_one);
`default_nettype wire

// ==== ir_optics.sv ====
// far side of the optical port: a detector lit by the bench and an led
// assumes a low transmit pin lights the led; lit cycles are counted
`timescale 1ns/1ns
`default_nettype none
module ir_optics (
  input wire logic clk_sys, // clock
  input wire logic light, // light on the detector
  input wire logic clr, // clears the lit count
  input wire logic ir_tx_pin, // led drive
  output logic ir_rx_pin, // comparator result
  output logic [15:0] lit_count // cycles with the led lit
);
  assign ir_rx_pin = light;
  always_ff @(posedge clk_sys)
  begin
    if (clr)
      lit_count <= 16'h0000;
    else if (!ir_tx_pin)
      lit_count <= lit_count + 16'h0001;
  end
endmodule
`default_nettype wire

// ==== tb_top.sv ====
// self-checking bench: axi4-lite register access, pin routing and pulse shaping
// assumes the design, its checker and the optics model compile first
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  import optical_pulse_pkg::*;
  localparam int unsigned SC = 20;
  localparam int unsigned PER = 16 * CARRIER_STEP_CYCLES;
  logic clk_sys = 0, rst_b = 0, light = 1, clr = 0;
  logic [ADDR_W-1:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
  logic s_axi_rready = 0, uart_tx = 1, general_io_line_two = 0;
  logic [1:0] ce_pulse = 2'h0, s_axi_bresp, s_axi_rresp;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic real_energy_pulse, reactive_energy_pulse, uart_rx, general_io_line_one;
  logic ir_tx_pin, ir_rx_pin;
  logic [15:0] lit_count;
  int bad_count = 0, checks = 0;
  optical_pulse #(.SAMPLE_CYC(SC)) dut (.clk_sys, .rst_b, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .ce_pulse, .real_energy_pulse,
    .reactive_energy_pulse, .ir_rx_pin, .uart_rx, .general_io_line_one, .uart_tx,
    .general_io_line_two, .ir_tx_pin);
  ir_optics u_optics (.clk_sys, .light, .clr, .ir_tx_pin, .ir_rx_pin, .lit_count);
  initial forever #2 clk_sys = ~clk_sys;
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e)
    begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic chk_rng(input string n, input int lo, input int hi, input int g);
    checks++;
    if (g < lo || g > hi)
    begin
      bad_count++;
      $display("CHECK FAILED %s expected %0d to %0d seen %0d", n, lo, hi, g);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
  endtask
  // one extra edge after each response so the next call never lands in the same step
  task automatic wr(input logic [15:0] i, input logic [7:0] d, input logic [1:0] er = RESP_OKAY);
    s_axi_awaddr <= ADDR_W'({i, 2'b00});
    s_axi_wdata <= {24'h000000, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do
    begin
      @(posedge clk_sys);
      s_axi_awvalid <= s_axi_awvalid && !s_axi_awready;
      s_axi_wvalid <= s_axi_wvalid && !s_axi_wready;
    end
    while ((s_axi_awvalid && !s_axi_awready) || (s_axi_wvalid && !s_axi_wready));
    do @(posedge clk_sys); while (s_axi_bvalid !== 1'b1);
    chk("bresp", er, s_axi_bresp);
    s_axi_bready <= 1'b0;
    @(posedge clk_sys);
  endtask
  task automatic rd(input logic [15:0] i, input logic [7:0] e, input logic [1:0] er = RESP_OKAY);
    s_axi_araddr <= ADDR_W'({i, 2'b00});
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge clk_sys); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge clk_sys); while (s_axi_rvalid !== 1'b1);
    chk("rdata", {24'h000000, e}, s_axi_rdata);
    chk("rresp", er, s_axi_rresp);
    s_axi_rready <= 1'b0;
    @(posedge clk_sys);
  endtask
  task automatic fire(input int b);
    ce_pulse[b] <= 1'b1;
    @(posedge clk_sys);
    ce_pulse[b] <= 1'b0;
  endtask
  task automatic real_width(output int w);
    fire(0);
    cyc(2);
    chk("real start", 1'b0, real_energy_pulse);
    w = 0;
    while (real_energy_pulse === 1'b0 && w < 5000)
    begin
      @(posedge clk_sys);
      w++;
    end
  endtask
  // a full carrier period gives an exact lit count whatever the phase
  task automatic lit_window;
    cyc(2);
    clr <= 1'b1;
    @(posedge clk_sys);
    clr <= 1'b0;
    cyc(PER + 1);
  endtask
  task automatic end_sim;
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  initial
  begin
    cyc(100000);
    bad_count++;
    end_sim();
  end
  initial
  begin
    int w;
    cyc(3);
    rst_b <= 1'b1;
    rd(IDX_MAX_WIDTH, RST_MAX_WIDTH);
    rd(IDX_INTERVAL, RST_INTERVAL);
    rd(IDX_OPT_SEL, 8'h00);
    rd(IDX_OPT_CTRL, 8'h00);
    rd(IDX_PULSE_CTRL, 8'h00);
    rd(IDX_STATUS, 8'h0F);
    rd(16'h2000, 8'h00, RESP_SLVERR);
    wr(16'h2000, 8'h5A, RESP_SLVERR);
    wr(IDX_INTERVAL, 8'h51);
    rd(IDX_INTERVAL, 8'h51);
    wr(IDX_INTERVAL, 8'h00);
    $display("test registers done");
    for (int s = 0; s < 4; s++)
      for (int k = 0; k < 4; k++)
      begin
        wr(IDX_OPT_SEL, 8'(s << POS_TX_SRC));
        wr(IDX_OPT_CTRL, 8'(k[1] << POS_TX_INVERT));
        uart_tx <= k[0];
        general_io_line_two <= !k[0];
        cyc(3);
        chk("tx pin", (s == 0 ? k[0] : (s == 1 ? !k[0] : 1'b1)) ^ k[1], ir_tx_pin);
      end
    $display("test tx source done");
    for (int k = 0; k < 8; k++)
    begin
      wr(IDX_OPT_CTRL, 8'({k[2], k[1]}) << POS_RX_INVERT);
      light <= k[0];
      cyc(3);
      chk("uart rx", k[2] ? 1'b1 : k[0] ^ k[1], uart_rx);
      chk("line one", k[2] & k[0], general_io_line_one);
    end
    $display("test rx pin done");
    wr(IDX_MAX_WIDTH, 8'h01);
    wr(IDX_OPT_SEL, 8'(SRC_REACTIVE) << POS_TX_SRC);
    wr(IDX_OPT_CTRL, 8'h00);
    fire(1);
    cyc(3);
    chk("tx from reactive", 1'b0, ir_tx_pin);
    chk("real idle", 1'b1, real_energy_pulse);
    real_width(w);
    chk_rng("limited width", 2 * SC - 1, 3 * SC + 1, w);
    wr(IDX_MAX_WIDTH, MAX_WIDTH_OFF);
    fire(0);
    cyc(100);
    real_width(w);
    chk_rng("half spacing", 48, 53, w);
    $display("test pulse width done");
    uart_tx <= 1'b0;
    wr(IDX_OPT_CTRL, 8'(1 << POS_TX_MOD));
    for (int d = 0; d < 4; d++)
    begin
      wr(IDX_OPT_SEL, 8'(d << POS_DUTY));
      lit_window();
      chk("carrier low", (16 >> (d + 1)) * CARRIER_STEP_CYCLES, lit_count);
    end
    uart_tx <= 1'b1;
    lit_window();
    chk("high unmodulated", 0, lit_count);
    wr(IDX_OPT_CTRL, 8'h03);
    lit_window();
    // duty select still holds the last loop value, 6.25 percent low
    chk("inverted then modulated", CARRIER_STEP_CYCLES, lit_count);
    $display("test modulation done");
    wr(IDX_PULSE_CTRL, 8'(1 << POS_PULSE_INV));
    cyc(3);
    chk("real idle inverted", 1'b0, real_energy_pulse);
    fire(1);
    cyc(2);
    chk("reactive active high", 1'b1, reactive_energy_pulse);
    $display("test polarity done");
    end_sim();
  end
endmodule
`default_nettype wire
